/* File: common/smcs_consts.vh */
// Constants for the sensor matrix change scanner
`ifndef SMCS_CONSTS_VH
`define SMCS_CONSTS_VH
`define SMCS_ROWS 16
`define SMCS_ROW_W 4
`define SMCS_COL_W 8
`define SMCS_ROW_LAST 4'hf
`define SMCS_ROW_FIRST 4'h0
`define SMCS_COL_PRESET 4'h8
`define SMCS_COL_ZERO 4'h0
`define SMCS_STATE_BIT 7
`define SMCS_FIFO_LO 6'h00
`define SMCS_FIFO_HI 6'h27
`define SMCS_FIFO_AW 6
`define SMCS_SCAN_TIME_NS 2000000
`define SMCS_CLK_NS 10
`define SMCS_SETTLE_CYC 4'h3
`endif

/* File: design/smcs_change_fifo.v */
// Circular change-word FIFO with wrapping in/out pointers
`timescale 1ns/1ps
`include "smcs_consts.vh"
module smcs_change_fifo #(
  parameter [`SMCS_FIFO_AW-1:0] LO = `SMCS_FIFO_LO,
  parameter [`SMCS_FIFO_AW-1:0] HI = `SMCS_FIFO_HI
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Write side
  input wire wr_i,
  input wire [7:0] wr_data_i,
  // Read side
  input wire rd_i,
  output wire [7:0] rd_data_o,
  // Status
  output wire empty_o,
  output wire full_o
);
  localparam DEPTH = HI - LO + 1;
  reg [7:0] mem_r [0:DEPTH-1];
  reg [`SMCS_FIFO_AW-1:0] in_r;
  reg [`SMCS_FIFO_AW-1:0] out_r;
  reg [`SMCS_FIFO_AW:0] cnt_r;

  function [`SMCS_FIFO_AW-1:0] bump;
    input [`SMCS_FIFO_AW-1:0] p;
    begin
      bump = (p == HI) ? LO : p + 1'b1;
    end
  endfunction

  assign empty_o = (cnt_r == {(`SMCS_FIFO_AW+1){1'b0}});
  assign full_o = (cnt_r == DEPTH[`SMCS_FIFO_AW:0]);
  assign rd_data_o = mem_r[out_r - LO];

  // A full FIFO still takes a word when the oldest leaves in the same cycle.
  // The shared slot is read before it is rewritten, so no change word is lost.
  wire rd_ok = rd_i && !empty_o;
  wire wr_ok = wr_i && (!full_o || rd_ok);

  always @(posedge clock_i) begin
    if (rst_i) begin
      in_r <= LO;
      out_r <= LO;
      cnt_r <= {(`SMCS_FIFO_AW+1){1'b0}};
    end else begin
      if (wr_ok) begin
        mem_r[in_r - LO] <= wr_data_i;
        in_r <= bump(in_r);
      end
      if (rd_ok)
        out_r <= bump(out_r);
      case ({wr_ok, rd_ok})
        2'b10: cnt_r <= cnt_r + 1'b1;
        2'b01: cnt_r <= cnt_r - 1'b1;
        default: cnt_r <= cnt_r;
      endcase
    end
  end
endmodule // smcs_change_fifo

/* File: design/smcs_scanner.v */
// Sensor matrix scanner: row drive, change detection, output buffer management
`timescale 1ns/1ps
`include "smcs_consts.vh"
// Operation
// - Scan 16x8 matrix via 4-bit row code
// - Select rows in order, sample columns
// - Selected row low; low return means closed
// - Compare row against previous scan
// - Keep 16-byte previous map, update each scan
// - Encode change byte, offer via read buffer
// - Buffer busy: queue change in 40-entry FIFO
// - Flags as status bits and pins
// - Pending pin high while FIFO holds words
// - Move oldest entry when buffer free
// - FIFO is circular with two pointers
// - Row counter gives coordinate row part
// - FIFO bounds are build-time parameters
// - Bit 7 state, low bits coordinate
// - Shift difference left, column counter from 8
// - FIFO full and buffer full stalls scan
// - Pointers wrap from top to bottom
module smcs_scanner #(
  parameter SCAN_CYC = `SMCS_SCAN_TIME_NS / `SMCS_CLK_NS,
  parameter [`SMCS_FIFO_AW-1:0] FIFO_LO = `SMCS_FIFO_LO,
  parameter [`SMCS_FIFO_AW-1:0] FIFO_HI = `SMCS_FIFO_HI
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Matrix pins
  output reg [`SMCS_ROW_W-1:0] row_code_o,
  input wire [`SMCS_COL_W-1:0] col_return_i,
  // Master side
  input wire host_rd_i,
  output reg [7:0] host_read_buffer_o,
  output reg [7:0] status_o,
  output reg read_buffer_full_pin_o,
  output reg pending_changes_pin_o
);
  localparam S_INIT = 3'h0;
  localparam S_SETTLE = 3'h1;
  localparam S_SAMPLE = 3'h2;
  localparam S_DECODE = 3'h3;
  localparam S_WAIT = 3'h4;

  reg [2:0] state_r;
  reg init_r;
  reg [`SMCS_ROW_W-1:0] row_r;
  reg [3:0] col_r;
  reg [7:0] diff_r;
  reg [7:0] pres_r;
  reg [3:0] settle_r;
  reg [31:0] wait_r;
  reg [7:0] map_r [0:`SMCS_ROWS-1];
  reg [`SMCS_COL_W-1:0] col_m_r;
  reg [`SMCS_COL_W-1:0] col_s_r;
  reg read_buffer_full_flag_r;
  reg fifo_wr;
  reg fifo_rd;
  reg [7:0] fifo_wd;
  wire [7:0] fifo_rdata;
  wire fifo_empty;
  wire fifo_full;
  wire [`SMCS_COL_W-1:0] closed = ~col_s_r;

  smcs_change_fifo #(
    .LO(FIFO_LO),
    .HI(FIFO_HI)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_i(fifo_wr),
    .wr_data_i(fifo_wd),
    .rd_i(fifo_rd),
    .rd_data_o(fifo_rdata),
    .empty_o(fifo_empty),
    .full_o(fifo_full)
  );

  // A found change goes straight to the buffer only when both FIFO and buffer are idle, keeping order
  wire found = (state_r == S_DECODE) && diff_r[`SMCS_STATE_BIT];
  // The counter runs down from 8 while bit 7 leads, so the coordinate is 8 minus the counter
  wire [3:0] col_off = `SMCS_COL_PRESET - col_r;
  wire [2:0] col_idx = col_off[2:0];
  wire [7:0] change_word = {pres_r[`SMCS_STATE_BIT], row_r, col_idx[2:0]};
  wire direct = found && fifo_empty && !read_buffer_full_flag_r;
  wire stall = found && fifo_full && read_buffer_full_flag_r;

  always @* begin
    fifo_rd = !fifo_empty && !read_buffer_full_flag_r;
    fifo_wr = found && !direct && !stall;
    fifo_wd = change_word;
  end

  always @(posedge clock_i) begin
    col_m_r <= col_return_i;
    col_s_r <= col_m_r;
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      read_buffer_full_flag_r <= 1'b0;
      host_read_buffer_o <= 8'h00;
    end else if (fifo_rd) begin
      host_read_buffer_o <= fifo_rdata;
      read_buffer_full_flag_r <= 1'b1;
    end else if (direct) begin
      host_read_buffer_o <= change_word;
      read_buffer_full_flag_r <= 1'b1;
    end else if (host_rd_i) begin
      read_buffer_full_flag_r <= 1'b0;
    end
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      read_buffer_full_pin_o <= 1'b0;
      pending_changes_pin_o <= 1'b0;
      status_o <= 8'h00;
    end else begin
      read_buffer_full_pin_o <= read_buffer_full_flag_r || fifo_rd || direct;
      pending_changes_pin_o <= !fifo_empty || fifo_wr;
      status_o <= {6'h00, !fifo_empty || fifo_wr, read_buffer_full_flag_r || fifo_rd || direct};
    end
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= S_SETTLE;
      init_r <= 1'b1;
      row_r <= `SMCS_ROW_FIRST;
      row_code_o <= `SMCS_ROW_FIRST;
      col_r <= `SMCS_COL_ZERO;
      diff_r <= 8'h00;
      pres_r <= 8'h00;
      settle_r <= `SMCS_SETTLE_CYC;
      wait_r <= 32'h0;
    end else begin
      case (state_r)
        S_SETTLE: begin
          // Row code plus two-stage sampler needs a few cycles before returns are valid
          if (settle_r == `SMCS_COL_ZERO)
            state_r <= S_SAMPLE;
          else
            settle_r <= settle_r - 1'b1;
        end
        S_SAMPLE: begin
          map_r[row_r] <= closed;
          pres_r <= closed;
          diff_r <= init_r ? 8'h00 : (closed ^ map_r[row_r]);
          col_r <= `SMCS_COL_PRESET;
          state_r <= S_DECODE;
        end
        S_DECODE: begin
          if (!stall) begin
            if (col_r == `SMCS_COL_ZERO || diff_r == 8'h00) begin
              col_r <= `SMCS_COL_ZERO;
              if (row_r == `SMCS_ROW_LAST) begin
                init_r <= 1'b0;
                wait_r <= SCAN_CYC;
                state_r <= S_WAIT;
              end else begin
                state_r <= S_SETTLE;
                settle_r <= `SMCS_SETTLE_CYC;
              end
              row_r <= row_r + 1'b1;
              row_code_o <= row_r + 1'b1;
            end else begin
              diff_r <= {diff_r[6:0], 1'b0};
              pres_r <= {pres_r[6:0], 1'b0};
              col_r <= col_r - 1'b1;
            end
          end
        end
        S_WAIT: begin
          if (wait_r == 32'h0) begin
            state_r <= S_SETTLE;
            settle_r <= `SMCS_SETTLE_CYC;
          end else
            wait_r <= wait_r - 1'b1;
        end
        default: state_r <= S_SETTLE;
      endcase
    end
  end
endmodule // smcs_scanner

/* File: sim/smcs_host_model.sv */
// Host master model that reads change words
`timescale 1ns/1ps
module smcs_host_model (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Control
  input wire stall_i,
  input wire pin_i,
  output reg host_rd_o = 1'b0
);
  int gap = 0;
  // Gap covers the pin lag, so one word is never read twice
  always @(posedge clock_i) begin
    #1;
    if (gap > 0) begin
      gap--;
      host_rd_o = 1'b0;
    end else if (!rst_i && pin_i && !stall_i) begin
      host_rd_o = 1'b1;
      gap = 3;
    end else
      host_rd_o = 1'b0;
  end
endmodule // smcs_host_model

/* File: sim/smcs_scanner_asserts.sv */
// Port assertions for the change scanner
`timescale 1ns/1ps
module smcs_scanner_chk (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Watched ports
  input wire [3:0] row_code_o,
  input wire host_rd_i,
  input wire [7:0] host_read_buffer_o,
  input wire [7:0] status_o,
  input wire read_buffer_full_pin_o,
  input wire pending_changes_pin_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_held;
    (read_buffer_full_pin_o && !host_rd_i) [*3];
  endsequence
  property p_row;
    $changed(row_code_o) |-> row_code_o == $past(row_code_o) + 4'h1;
  endproperty
  a_row: assert property (p_row) else $error("row step");
  property p_hi;
    status_o[7:2] == 6'h00;
  endproperty
  a_hi: assert property (p_hi) else $error("status spare");
  property p_sf;
    $rose(status_o[0]) |-> ##[0:2] read_buffer_full_pin_o;
  endproperty
  a_sf: assert property (p_sf) else $error("full pin");
  property p_sp;
    $rose(status_o[1]) |-> ##[0:2] pending_changes_pin_o;
  endproperty
  a_sp: assert property (p_sp) else $error("pending pin");
  property p_pb;
    pending_changes_pin_o |-> ##[0:3] read_buffer_full_pin_o;
  endproperty
  a_pb: assert property (p_pb) else $error("fifo not drained");
  property p_pr;
    $rose(pending_changes_pin_o) |-> read_buffer_full_pin_o;
  endproperty
  a_pr: assert property (p_pr) else $error("queued while free");
  property p_rel;
    $fell(read_buffer_full_pin_o) |-> $past(host_rd_i) || $past(host_rd_i, 2);
  endproperty
  a_rel: assert property (p_rel) else $error("full dropped unread");
  property p_hold;
    s_held |-> $stable(host_read_buffer_o);
  endproperty
  a_hold: assert property (p_hold) else $error("word overwritten");
endmodule // smcs_scanner_chk

/* File: sim/test_smcs_scanner.sv */
// Bench for the change scanner
`timescale 1ns/1ps
module test_smcs_scanner;
  logic clock_i = 0, rst_i = 1, stall = 1, rd, fp, pp;
  logic [3:0] row, r;
  logic [7:0] rb, st, s [16] = '{default: 8'h00};
  logic [7:0] got [$];
  int errors = 0, checks_done = 0, i;
  // Selected row low, closed sensor pulls its return low
  wire [7:0] cr = ~s[row];
  smcs_scanner #(.SCAN_CYC(10)) u_dut (.clock_i(clock_i), .rst_i(rst_i), .row_code_o(row), .col_return_i(cr),
    .host_rd_i(rd), .host_read_buffer_o(rb), .status_o(st), .read_buffer_full_pin_o(fp), .pending_changes_pin_o(pp));
  smcs_host_model u_host (.clock_i(clock_i), .rst_i(rst_i), .stall_i(stall), .pin_i(fp), .host_rd_o(rd));
  always @(posedge clock_i) if (rd) got.push_back(rb);
  initial forever #5 clock_i = ~clock_i;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
    checks_done++;
    if (v !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_words(input int n);
    for (int k = 0; k < 4000 && got.size() < n; k++) @(posedge clock_i);
    #1;
    if (got.size() < n) begin
      chk("word_count", 8'(n), 8'(got.size()));
      report_and_stop();
    end
  endtask
  task automatic t_single;
    stall = 0;
    s[5] = 8'h04;
    wait_words(1);
    chk("word_close", {1'b1, 4'h5, 3'h5}, got[0]);
    repeat (5) @(posedge clock_i);
    #1 chk("status_idle", 8'h00, st);
    s[5] = 8'h00;
    wait_words(2);
    chk("word_open", {1'b0, 4'h5, 3'h5}, got[1]);
  endtask
  task automatic t_burst;
    stall = 1;
    got.delete();
    s[9] = 8'hff;
    for (i = 0; i < 2000 && pp !== 1'b1; i++) @(posedge clock_i);
    if (pp !== 1'b1) begin
      chk("pending_wait", 8'h01, {7'h0, pp});
      report_and_stop();
    end
    repeat (20) @(posedge clock_i);
    #1 chk("status_busy", 8'h03, st);
    chk("pending_pin", 8'h01, {7'h0, pp});
    stall = 0;
    wait_words(8);
    for (i = 0; i < 8; i++) chk("word_order", {1'b1, 4'h9, i[2:0]}, got[i]);
    repeat (5) @(posedge clock_i);
    #1 chk("pending_off", 8'h00, {7'h0, pp});
  endtask
  task automatic t_full;
    stall = 1;
    got.delete();
    foreach (s[k]) s[k] = 8'hff;
    repeat (1500) @(posedge clock_i);
    #1 r = row;
    repeat (100) @(posedge clock_i);
    #1 chk("row_stalled", {4'h0, r}, {4'h0, row});
    stall = 0;
    wait_words(120);
    repeat (300) @(posedge clock_i);
    #1 chk("word_total", 8'h78, 8'(got.size()));
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    #1 rst_i = 0;
    // The first scan only fills the map
    repeat (400) @(posedge clock_i);
    #1 t_single();
    t_burst();
    t_full();
    report_and_stop();
  end
endmodule // test_smcs_scanner
bind smcs_scanner smcs_scanner_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .row_code_o(row_code_o),
  .host_rd_i(host_rd_i), .host_read_buffer_o(host_read_buffer_o), .status_o(status_o),
  .read_buffer_full_pin_o(read_buffer_full_pin_o), .pending_changes_pin_o(pending_changes_pin_o));
